// >>> common/smrc_pkg.sv
package smrc_pkg;

   localparam int SMRC_ADDR_W = 8;
   localparam int SMRC_DATA_W = 8;

   // Register offsets
   localparam logic [SMRC_ADDR_W-1:0] SMRC_CTRL_OFS = 8'hff;
   localparam logic [SMRC_ADDR_W-1:0] SMRC_RESET_SOURCE_REGISTER_OFS = 8'hef;
   localparam logic [SMRC_ADDR_W-1:0] SMRC_IRQCFG_OFS = 8'hf0;
   localparam logic [SMRC_ADDR_W-1:0] SMRC_STATUS_OFS = 8'hf1;

   // Field positions
   localparam int SMRC_CTRL_ON_BIT = 7;
   localparam int SMRC_CTRL_ABOVE_BIT = 6;
   localparam int SMRC_CTRL_WARN_BIT = 5;
   localparam int SMRC_RESET_SOURCE_REGISTER_POR_BIT = 1;
   localparam int SMRC_IRQCFG_EN_BIT = 0;
   localparam int SMRC_STATUS_PF_BIT = 0;
   localparam int SMRC_STATUS_HOLD_BIT = 1;

   // Reset values
   localparam logic SMRC_ON_RST = 1'b1;
   localparam logic SMRC_SEL_RST = 1'b1;
   localparam logic SMRC_POR_RST = 1'b1;
   localparam logic SMRC_IRQEN_RST = 1'b0;
   localparam logic SMRC_PF_RST = 1'b0;
   localparam logic [SMRC_DATA_W-1:0] SMRC_RD_RST = 8'h00;

   // Comparator channels
   localparam int SMRC_NUM_CMP = 2;
   localparam int SMRC_CMP_RST_IDX = 0;
   localparam int SMRC_CMP_WARN_IDX = 1;
   localparam logic [SMRC_NUM_CMP-1:0] SMRC_SYNC_RST = 2'h3;

   typedef enum logic [0:0]
   {
      SMRC_RUN = 1'b0,
      SMRC_HOLD = 1'b1
   } smrc_state_e;

endpackage

// >>> common/smrc_sync_if.sv
`timescale 1ns/1ps
interface smrc_sync_if;
   logic [smrc_pkg::SMRC_NUM_CMP-1:0] raw;
   logic [smrc_pkg::SMRC_NUM_CMP-1:0] synced;

   modport owner (output raw, input synced);
   modport syncr (input raw, output synced);
endinterface

// >>> design/smrc_sync.sv
`timescale 1ns/1ps
module smrc_sync
(
   input wire logic ref_clk,
   input wire logic resetn,
   smrc_sync_if.syncr cmp
);
   import smrc_pkg::*;

   typedef struct packed
   {
      logic [SMRC_NUM_CMP-1:0] stage1;
      logic [SMRC_NUM_CMP-1:0] stage2;
   } smrc_sync_s;

   smrc_sync_s st;
   smrc_sync_s next_st;

   // Reset to "above" so a fresh power-on does not see a false dip
   always_comb
   begin
      next_st = st;
      next_st.stage1 = cmp.raw;
      next_st.stage2 = st.stage1;
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st <= '{stage1: SMRC_SYNC_RST, stage2: SMRC_SYNC_RST};
      end
      else
      begin
         st <= next_st;
      end
   end

   genvar i;
   generate
      for (i = 0; i < SMRC_NUM_CMP; i++)
      begin : g_out
         assign cmp.synced[i] = st.stage2[i];
      end
   endgenerate

endmodule // smrc_sync

// >>> design/smrc_top.sv
// Function
// - Power-on and power-fail resets leave the monitor on and selected as reset source.
// - Monitor on and selected, supply below reset level: drive reset pin, hold core.
// - After a power-fail reset the power-on flag and select bit read one.
// - Only power-on and power-fail resets change monitor enable and selection.
// - Sleep inhibits the power-fail reset; stored settings return on wake.
// - Early-warning bit is zero at or below warning level, one above it.
// - Early-warning status drives an interrupt request that software can enable.
// - Flash erase or write with monitor off gives a flash-error system reset.
// - Leaving a monitor reset adds no power-on delay; ends when supply recovers.
// - Selecting the monitor lets it assert reset at once, even unsettled.
// - Control bit 7 turns the monitor on; it resets only when also selected.
// - Read-only bit 6 shows supply above the reset level live.
// - Read-only bit 5 shows the live early-warning supply status.
// - Control bits 4 to 2 read zero; software writes zero there.
// - Control bits 1 to 0 read zero; writes to them do nothing.
// - Power-on/select bit sits at bit 1 of reset-source register, set after power-on.
// - Other resets clear the power-on flag.
`timescale 1ns/1ps
module smrc_top
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [smrc_pkg::SMRC_ADDR_W-1:0] regAddr,
   input wire logic [smrc_pkg::SMRC_DATA_W-1:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [smrc_pkg::SMRC_DATA_W-1:0] regRdData,
   input wire logic supplyAboveResetRaw,
   input wire logic supplyAboveWarnRaw,
   input wire logic sleepMode,
   input wire logic otherResetReq,
   input wire logic flashWriteReq,
   output logic supplyMonitorOn,
   output logic rstPinOut,
   output logic rstPinOe,
   output logic coreResetHold,
   output logic flashErrorReset,
   output logic earlyWarnIrq
);
   import smrc_pkg::*;

   typedef struct packed
   {
      smrc_state_e state;
      logic on;
      logic sel;
      logic porFlag;
      logic irqEn;
      logic pfSticky;
      logic [SMRC_DATA_W-1:0] rdData;
      logic rstOut;
      logic rstOe;
      logic coreHold;
      logic flashErr;
      logic irq;
   } smrc_top_s;

   localparam smrc_top_s ST_RST = '{
      state: SMRC_RUN,
      on: SMRC_ON_RST,
      sel: SMRC_SEL_RST,
      porFlag: SMRC_POR_RST,
      irqEn: SMRC_IRQEN_RST,
      pfSticky: SMRC_PF_RST,
      rdData: SMRC_RD_RST,
      rstOut: 1'b1,
      rstOe: 1'b0,
      coreHold: 1'b0,
      flashErr: 1'b0,
      irq: 1'b0
   };

   smrc_top_s st;
   smrc_top_s next_st;

   logic aboveRst;
   logic aboveWarn;
   logic resetArmed;
   logic holdNext;
   logic busLive;
   logic hitCtrl;
   logic hitRstSrc;
   logic hitIrqCfg;
   logic hitStatus;
   logic wrCtrl;
   logic wrRstSrc;
   logic wrIrqCfg;
   logic wrStatus;
   logic dipSeen;
   logic flashFault;

   smrc_sync_if cmp ();

   assign cmp.raw[SMRC_CMP_RST_IDX] = supplyAboveResetRaw;
   assign cmp.raw[SMRC_CMP_WARN_IDX] = supplyAboveWarnRaw;

   smrc_sync u_sync
   (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .cmp(cmp)
   );

   assign aboveRst = cmp.synced[SMRC_CMP_RST_IDX];
   assign aboveWarn = cmp.synced[SMRC_CMP_WARN_IDX];

   // Stored enable and select are untouched in sleep, so waking restores them
   assign resetArmed = st.on & st.sel & ~sleepMode;

   // Requests from a held core are dropped, never queued
   assign busLive = (st.state == SMRC_RUN);
   assign hitCtrl = (regAddr == SMRC_CTRL_OFS);
   assign hitRstSrc = (regAddr == SMRC_RESET_SOURCE_REGISTER_OFS);
   assign hitIrqCfg = (regAddr == SMRC_IRQCFG_OFS);
   assign hitStatus = (regAddr == SMRC_STATUS_OFS);
   assign wrCtrl = regWrite & busLive & hitCtrl;
   assign wrRstSrc = regWrite & busLive & hitRstSrc;
   assign wrIrqCfg = regWrite & busLive & hitIrqCfg;
   assign wrStatus = regWrite & busLive & hitStatus;

   assign dipSeen = resetArmed & ~aboveRst;
   // Checks enable only; selection does not guard flash
   assign flashFault = flashWriteReq & ~st.on & busLive;

   // Bits 4:0 hold no storage, so they always read zero
   function automatic logic [SMRC_DATA_W-1:0] ctrl_image
   (
      input logic monOn,
      input logic above,
      input logic warnOk
   );
      logic [SMRC_DATA_W-1:0] img;
      img = SMRC_RD_RST;
      img[SMRC_CTRL_ON_BIT] = monOn;
      img[SMRC_CTRL_ABOVE_BIT] = above;
      img[SMRC_CTRL_WARN_BIT] = warnOk;
      return img;
   endfunction

   // Reads the flag, while writes land in the select flop
   function automatic logic [SMRC_DATA_W-1:0] reset_source_register_image
   (
      input logic flag
   );
      logic [SMRC_DATA_W-1:0] img;
      img = SMRC_RD_RST;
      img[SMRC_RESET_SOURCE_REGISTER_POR_BIT] = flag;
      return img;
   endfunction

   function automatic logic [SMRC_DATA_W-1:0] irqcfg_image
   (
      input logic enable
   );
      logic [SMRC_DATA_W-1:0] img;
      img = SMRC_RD_RST;
      img[SMRC_IRQCFG_EN_BIT] = enable;
      return img;
   endfunction

   // Hold bit reads zero: a held core cannot read at all
   function automatic logic [SMRC_DATA_W-1:0] status_image
   (
      input logic pfSeen
   );
      logic [SMRC_DATA_W-1:0] img;
      img = SMRC_RD_RST;
      img[SMRC_STATUS_PF_BIT] = pfSeen;
      img[SMRC_STATUS_HOLD_BIT] = 1'b0;
      return img;
   endfunction

   // One byte per address; unmapped reads give zero
   function automatic logic [SMRC_DATA_W-1:0] read_mux
   (
      input logic [SMRC_ADDR_W-1:0] addr,
      input smrc_top_s cur,
      input logic above,
      input logic warnOk
   );
      logic [SMRC_DATA_W-1:0] img;
      case (addr)
         SMRC_CTRL_OFS:
         begin
            img = ctrl_image(cur.on, above, warnOk);
         end
         SMRC_RESET_SOURCE_REGISTER_OFS:
         begin
            img = reset_source_register_image(cur.porFlag);
         end
         SMRC_IRQCFG_OFS:
         begin
            img = irqcfg_image(cur.irqEn);
         end
         SMRC_STATUS_OFS:
         begin
            img = status_image(cur.pfSticky);
         end
         default:
         begin
            img = SMRC_RD_RST;
         end
      endcase
      return img;
   endfunction

   // Software writes only; the hold logic may still override them
   function automatic smrc_top_s write_update
   (
      input smrc_top_s cur,
      input logic [SMRC_DATA_W-1:0] data,
      input logic toCtrl,
      input logic toRstSrc,
      input logic toIrqCfg,
      input logic toStatus
   );
      smrc_top_s upd;
      upd = cur;
      if (toCtrl)
      begin
         // Only bit 7 is stored; the rest is dropped
         upd.on = data[SMRC_CTRL_ON_BIT];
      end
      if (toRstSrc)
      begin
         // Takes effect next cycle, no settling guard
         upd.sel = data[SMRC_RESET_SOURCE_REGISTER_POR_BIT];
      end
      if (toIrqCfg)
      begin
         upd.irqEn = data[SMRC_IRQCFG_EN_BIT];
      end
      if (toStatus && data[SMRC_STATUS_PF_BIT])
      begin
         upd.pfSticky = 1'b0;
      end
      return upd;
   endfunction

   // Power-fail hold; forced bits leave the monitor armed on release
   function automatic smrc_top_s hold_step
   (
      input smrc_top_s cur,
      input smrc_top_s upd,
      input logic dip,
      input logic above
   );
      smrc_top_s res;
      res = upd;
      case (cur.state)
         SMRC_RUN:
         begin
            if (dip)
            begin
               res.state = SMRC_HOLD;
               res.on = 1'b1;
               res.sel = 1'b1;
               res.porFlag = 1'b1;
               res.pfSticky = 1'b1;
            end
         end
         SMRC_HOLD:
         begin
            res.on = 1'b1;
            res.sel = 1'b1;
            res.porFlag = 1'b1;
            if (above)
            begin
               // No extra delay on release
               res.state = SMRC_RUN;
            end
         end
         default:
         begin
            res.state = SMRC_RUN;
         end
      endcase
      return res;
   endfunction

   always_comb
   begin
      next_st = st;
      next_st.flashErr = 1'b0;
      next_st.rdData = SMRC_RD_RST;

      // Core is held during a monitor reset, so its bus is ignored then
      if (regRead && busLive)
      begin
         next_st.rdData = read_mux(regAddr, st, aboveRst, aboveWarn);
      end

      next_st = write_update(next_st, regWrData, wrCtrl, wrRstSrc, wrIrqCfg, wrStatus);

      // Non-power reset clears the flag but keeps enable and select
      if (otherResetReq)
      begin
         next_st.porFlag = 1'b0;
      end

      // Hardware sets come last so they win over a same-cycle clear
      next_st = hold_step(st, next_st, dipSeen, aboveRst);

      holdNext = (next_st.state == SMRC_HOLD);
      next_st.coreHold = holdNext;
      next_st.rstOe = holdNext;
      next_st.rstOut = ~holdNext;

      if (flashFault)
      begin
         next_st.flashErr = 1'b1;
      end

      // Request stands while supply is at or below warning level
      next_st.irq = st.irqEn & ~aboveWarn;
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st <= ST_RST;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign regRdData = st.rdData;
   assign supplyMonitorOn = st.on;
   assign rstPinOut = st.rstOut;
   assign rstPinOe = st.rstOe;
   assign coreResetHold = st.coreHold;
   assign flashErrorReset = st.flashErr;
   assign earlyWarnIrq = st.irq;

endmodule // smrc_top

// >>> sim/smrc_top_asserts.sv
`timescale 1ns/1ps
module smrc_top_asserts
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [smrc_pkg::SMRC_ADDR_W-1:0] regAddr,
   input wire logic [smrc_pkg::SMRC_DATA_W-1:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [smrc_pkg::SMRC_DATA_W-1:0] regRdData,
   input wire logic supplyAboveResetRaw,
   input wire logic supplyAboveWarnRaw,
   input wire logic sleepMode,
   input wire logic flashWriteReq,
   input wire logic supplyMonitorOn,
   input wire logic rstPinOut,
   input wire logic rstPinOe,
   input wire logic coreResetHold,
   input wire logic flashErrorReset,
   input wire logic earlyWarnIrq
);
   import smrc_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // Raw level seen, two sync stages later hold still up
   sequence s_recover;
      supplyAboveResetRaw ##2 coreResetHold;
   endsequence
   a_hold_cause: assert property ($rose(coreResetHold) |->
      !$past(supplyAboveResetRaw, 3) && !$past(sleepMode) && $past(supplyMonitorOn))
      else $error("hold without armed low supply");
   a_hold_release: assert property (s_recover |=> !coreResetHold)
      else $error("hold outlasts recovery");
   a_pin_drive: assert property (rstPinOe == coreResetHold && rstPinOut == !coreResetHold)
      else $error("pin disagrees with hold");
   a_flash_error: assert property (flashWriteReq && !supplyMonitorOn && !coreResetHold |=> flashErrorReset)
      else $error("flash error missing");
   a_flash_cause: assert property (flashErrorReset |-> $past(flashWriteReq) && !$past(supplyMonitorOn))
      else $error("flash error without cause");
   a_irq_cause: assert property (earlyWarnIrq |-> !$past(supplyAboveWarnRaw, 3))
      else $error("irq while supply above warning");
   a_ctrl_read: assert property ($past(regRead) && $past(regAddr) == SMRC_CTRL_OFS && !$past(coreResetHold)
      |-> regRdData[4:0] == 5'h00 && regRdData[6] == $past(supplyAboveResetRaw, 3)
      && regRdData[5] == $past(supplyAboveWarnRaw, 3))
      else $error("control read wrong");
   a_mon_write: assert property (regWrite && regAddr == SMRC_CTRL_OFS && !coreResetHold
      |=> coreResetHold || supplyMonitorOn == $past(regWrData[SMRC_CTRL_ON_BIT]))
      else $error("monitor enable not written");
   a_reset_on: assert property (!$past(resetn) |-> supplyMonitorOn)
      else $error("monitor off after reset");
endmodule // smrc_top_asserts
bind smrc_top smrc_top_asserts chk (.*);

// >>> sim/smrc_supply_model.sv
`timescale 1ns/1ps
module smrc_supply_model
#(
   parameter int RST_MV = 1800,
   parameter int WARN_MV = 2000
)
(
   input int supplyMv,
   output logic aboveRst,
   output logic aboveWarn
);
   // Comparator edges land off the clock grid, as analogue ones do
   assign #3 aboveRst = supplyMv > RST_MV;
   assign #3 aboveWarn = supplyMv > WARN_MV;
endmodule // smrc_supply_model

// >>> sim/supply_monitor_reset_control_bench.sv
`timescale 1ns/1ps
module supply_monitor_reset_control_bench;
   import smrc_pkg::*;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic [SMRC_ADDR_W-1:0] regAddr = 8'h00;
   logic [SMRC_DATA_W-1:0] regWrData = 8'h00, regRdData;
   logic regWrite = 1'b0, regRead = 1'b0, sleepMode = 1'b0, otherResetReq = 1'b0, flashWriteReq = 1'b0;
   logic supplyAboveResetRaw, supplyAboveWarnRaw, supplyMonitorOn, rstPinOut, rstPinOe;
   logic coreResetHold, flashErrorReset, earlyWarnIrq;
   int supplyMv = 3000;
   int fails = 0;
   int comparisons = 0;
   always #5 ref_clk = ~ref_clk;
   smrc_supply_model model (.supplyMv(supplyMv), .aboveRst(supplyAboveResetRaw), .aboveWarn(supplyAboveWarnRaw));
   smrc_top uut (.*);
   task chk(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1)
      begin
         fails++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge ref_clk);
      regWrite <= 1'b0;
      #1;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input string msg);
      @(posedge ref_clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRead <= 1'b0;
      #1;
      chk((regRdData & m) === e, msg);
   endtask
   task flash_try(input logic e, input string msg);
      @(posedge ref_clk);
      flashWriteReq <= 1'b1;
      @(posedge ref_clk);
      flashWriteReq <= 1'b0;
      #1;
      chk(flashErrorReset === e, msg);
   endtask
   task t_power_up;
      chk(supplyMonitorOn === 1'b1, "monitor off");
      rd(SMRC_CTRL_OFS, 8'hff, 8'he0, "control at start");
      rd(SMRC_RESET_SOURCE_REGISTER_OFS, 8'h02, 8'h02, "power-on flag");
   endtask
   task t_enable_flash;
      wr(SMRC_CTRL_OFS, 8'h03);
      chk(supplyMonitorOn === 1'b0, "monitor stays on");
      rd(SMRC_CTRL_OFS, 8'hff, 8'h60, "unused bits");
      flash_try(1'b1, "no flash error");
      wr(SMRC_CTRL_OFS, 8'h80);
      flash_try(1'b0, "spurious flash error");
   endtask
   task t_other_reset;
      wr(SMRC_RESET_SOURCE_REGISTER_OFS, 8'h00);
      @(posedge ref_clk);
      otherResetReq <= 1'b1;
      @(posedge ref_clk);
      otherResetReq <= 1'b0;
      rd(SMRC_RESET_SOURCE_REGISTER_OFS, 8'h02, 8'h00, "flag kept");
      supplyMv = 1700;
      repeat (6) @(posedge ref_clk);
      #1;
      chk(coreResetHold === 1'b0, "unselected monitor held core");
      supplyMv = 3000;
      repeat (4) @(posedge ref_clk);
      wr(SMRC_CTRL_OFS, 8'h00);
      @(posedge ref_clk);
      otherResetReq <= 1'b1;
      @(posedge ref_clk);
      otherResetReq <= 1'b0;
      rd(SMRC_CTRL_OFS, 8'h80, 8'h00, "enable changed");
      wr(SMRC_CTRL_OFS, 8'h80);
      wr(SMRC_RESET_SOURCE_REGISTER_OFS, 8'h02);
   endtask
   task t_power_fail;
      supplyMv = 1700;
      repeat (5) @(posedge ref_clk);
      #1;
      chk(coreResetHold === 1'b1 && rstPinOe === 1'b1 && rstPinOut === 1'b0, "no hold");
      rd(SMRC_CTRL_OFS, 8'hff, 8'h00, "read during hold");
      supplyMv = 3000;
      repeat (3) @(posedge ref_clk);
      #1;
      chk(coreResetHold === 1'b0, "late release");
      rd(SMRC_RESET_SOURCE_REGISTER_OFS, 8'h02, 8'h02, "flag after fail");
      rd(SMRC_STATUS_OFS, 8'h03, 8'h01, "power-fail not recorded");
      wr(SMRC_STATUS_OFS, 8'h01);
      rd(SMRC_STATUS_OFS, 8'h03, 8'h00, "power-fail record stuck");
      rd(SMRC_CTRL_OFS, 8'h80, 8'h80, "enable after fail");
   endtask
   task t_sleep;
      @(posedge ref_clk);
      sleepMode <= 1'b1;
      supplyMv = 1700;
      repeat (6) @(posedge ref_clk);
      #1;
      chk(coreResetHold === 1'b0, "reset in sleep");
      supplyMv = 3000;
      repeat (4) @(posedge ref_clk);
      sleepMode <= 1'b0;
      rd(SMRC_CTRL_OFS, 8'h80, 8'h80, "enable lost in sleep");
      supplyMv = 1700;
      repeat (5) @(posedge ref_clk);
      #1;
      chk(coreResetHold === 1'b1, "select lost in sleep");
      supplyMv = 3000;
      repeat (4) @(posedge ref_clk);
   endtask
   task t_warn;
      wr(SMRC_IRQCFG_OFS, 8'h01);
      supplyMv = 1900;
      repeat (5) @(posedge ref_clk);
      #1;
      chk(earlyWarnIrq === 1'b1, "no warning irq");
      rd(SMRC_CTRL_OFS, 8'h60, 8'h40, "warning bit");
      wr(SMRC_IRQCFG_OFS, 8'h00);
      @(posedge ref_clk);
      #1;
      chk(earlyWarnIrq === 1'b0, "masked irq");
      supplyMv = 3000;
      repeat (4) @(posedge ref_clk);
      rd(SMRC_CTRL_OFS, 8'h60, 8'h60, "warning recovery");
   endtask
   task complete_run;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      #1;
      t_power_up();
      t_enable_flash();
      t_other_reset();
      t_power_fail();
      t_sleep();
      t_warn();
      complete_run();
   end
   initial
   begin
      #20000;
      fails++;
      complete_run();
   end
endmodule // supply_monitor_reset_control_bench
